//--- hw/hcs_pkg.sv
// Constants and state types for the hub clock and strap block
package hcs_pkg;
	localparam int CLK_PERIOD_NS = 25;
	localparam int OVC_FILT_NS = 100;
	localparam int OVC_FILT_CYC = (OVC_FILT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int BUS_CLK_DIV = 4;
	localparam int NUM_PORTS = 4;

	localparam logic [11:0] ADDR_STRAP_STATUS = 12'h000;
	localparam logic [11:0] ADDR_PORT_CTRL = 12'h004;
	localparam logic [11:0] ADDR_PORT_STATUS = 12'h008;
	localparam logic [11:0] ADDR_EE_CTRL = 12'h00c;

	localparam int STRAP_CLK_SRC_BIT = 0;
	localparam int STRAP_PWR_SRC_BIT = 1;
	localparam int STRAP_EE_DIS_BIT = 2;
	localparam int STRAP_GANG_BIT = 3;
	localparam int STRAP_CAPTURED_BIT = 4;
	localparam int CTRL_GANG_SW_BIT = 4;
	localparam int STAT_LATCH_LSB = 4;
	localparam int STAT_PWR_LSB = 8;
	localparam int EE_CLK_BIT = 0;
	localparam int EE_DOUT_BIT = 1;
	localparam int EE_DOE_BIT = 2;
	localparam int EE_DIN_BIT = 3;

	localparam logic [3:0] PWR_REQ_RST = 4'h0;
	localparam logic [1:0] DIV_RST = 2'h0;
	localparam logic [31:0] PRDATA_RST = 32'h0000_0000;

	typedef struct packed {
		logic [2:0] cnt;
		logic ovc;
	} hcs_filt_state_t;

	typedef struct packed {
		logic captured;
		logic clk_src;
		logic pwr_src;
		logic ee_dis;
		logic gang_pin;
		logic [3:0] pwr_req;
		logic gang_sw;
		logic [3:0] ovc_latch;
		logic [3:0] pwr_on;
		logic ee_clk;
		logic ee_dout;
		logic ee_doe;
		logic [1:0] div;
		logic bus_stb;
		logic [31:0] prdata;
		logic pslverr;
	} hcs_state_t;
endpackage : hcs_pkg

//--- hw/hcs_ovc_filter.sv
// Noise filter for one active-low overcurrent input
`timescale 1ns/100ps
`default_nettype none
module hcs_ovc_filter import hcs_pkg::*; (
	input wire logic clk,
	input wire logic rst,
	input wire logic ovc_raw_n,
	output logic ovc
);
	hcs_filt_state_t s_r, s_nxt;

	// A level must hold for the full filter time before it is believed
	always_comb begin
		s_nxt = s_r;
		if (~ovc_raw_n != s_r.ovc) begin
			if (s_r.cnt == 3'(OVC_FILT_CYC - 1)) begin
				s_nxt.ovc = ~ovc_raw_n;
				s_nxt.cnt = 3'h0;
			end else begin
				s_nxt.cnt = s_r.cnt + 3'h1;
			end
		end else begin
			s_nxt.cnt = 3'h0;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			s_r <= '0;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign ovc = s_r.ovc;
endmodule : hcs_ovc_filter
`default_nettype wire

//--- hw/hcs_clock_strap.sv
// Clock source selection, strap capture, port power and EEPROM pin control
//
// The APB slave port and the register addresses were decided locally.
`timescale 1ns/100ps
`default_nettype none
// Summary of operation
// - Strap low selects analog PLL output from the 6 MHz crystal as core clock.
// - Strap high selects external 48 MHz clock; PLL powered down and bypassed.
// - Crystal oscillator cell stays powered down while clock strap is high.
// - PLL mode makes 48 MHz internally and a synchronised 12 MHz bus clock.
// - Power strap high means bus-powered ports, low means self-powered.
// - EEPROM-disable strap high turns the EEPROM interface and clock pin off.
// - EEPROM enabled: serial clock is a three-state output with weak pulldown.
// - EEPROM enabled: shared pin is bidirectional EEPROM data with weak pulldown.
// - EEPROM disabled: shared pin selects ganged or per-port power handling.
// - Ganged mode switches all ports together; any overcurrent removes all power.
module hcs_clock_strap import hcs_pkg::*; (
	input wire logic CLOCK,
	input wire logic SYS_RST,
	input wire logic PSEL,
	input wire logic PENABLE,
	input wire logic PWRITE,
	input wire logic [11:0] PADDR,
	input wire logic [31:0] PWDATA,
	output logic [31:0] PRDATA,
	output logic PREADY,
	output logic PSLVERR,
	input wire logic CLOCK_SOURCE_STRAP,
	input wire logic POWER_SOURCE_STRAP,
	input wire logic EEPROM_DISABLE_STRAP,
	input wire logic EEPROM_DATA_OR_GANG_STRAP_I,
	output logic EEPROM_DATA_OR_GANG_STRAP_O,
	output logic EEPROM_DATA_OR_GANG_STRAP_OE,
	output logic EEPROM_DATA_PD_EN,
	output logic EEPROM_SERIAL_CLOCK_O,
	output logic EEPROM_SERIAL_CLOCK_OE,
	output logic EEPROM_SERIAL_CLOCK_PD_EN,
	output logic CORE_CLK_SEL_EXT,
	output logic ANALOG_PLL_PWRDN,
	output logic CRYSTAL_OSC_PWRDN,
	output logic BUS_CLK_SYNC,
	output logic BUS_POWERED,
	input wire logic [3:0] PORT_OVERCURRENT_N,
	output logic [3:0] PORT_POWER_ENABLE_N
);
	hcs_state_t s_r, s_nxt;
	logic [3:0] ovc_f;
	logic gang;
	logic setup;
	logic access_wr;

	genvar gi;
	generate
		for (gi = 0; gi < NUM_PORTS; gi++) begin : g_filt
			hcs_ovc_filter u_filt (
				.clk(CLOCK),
				.rst(SYS_RST),
				.ovc_raw_n(PORT_OVERCURRENT_N[gi]),
				.ovc(ovc_f[gi])
			);
		end
	endgenerate

	assign gang = s_r.ee_dis ? s_r.gang_pin : s_r.gang_sw;
	assign setup = PSEL & ~PENABLE;
	assign access_wr = PSEL & PENABLE & PWRITE;

	always_comb begin
		s_nxt = s_r;
		// Flops cannot load pins under async reset, so catch at first edge
		if (!s_r.captured) begin
			s_nxt.captured = 1'b1;
			s_nxt.clk_src = CLOCK_SOURCE_STRAP;
			s_nxt.pwr_src = POWER_SOURCE_STRAP;
			s_nxt.ee_dis = EEPROM_DISABLE_STRAP;
			s_nxt.gang_pin = EEPROM_DATA_OR_GANG_STRAP_I;
		end
		// Bus clock strobe, one in four core cycles
		if (s_r.captured) begin
			s_nxt.div = s_r.div + 2'h1;
		end
		s_nxt.bus_stb = s_r.captured && (s_r.div == 2'(BUS_CLK_DIV - 1));
		// Set wins over a same-cycle write-one clear
		s_nxt.ovc_latch = s_r.ovc_latch;
		if (access_wr && PADDR == ADDR_PORT_STATUS) begin
			s_nxt.ovc_latch = s_r.ovc_latch & ~PWDATA[STAT_LATCH_LSB +: 4];
		end
		s_nxt.ovc_latch = s_nxt.ovc_latch | ovc_f;
		for (int i = 0; i < NUM_PORTS; i++) begin
			if (gang) begin
				s_nxt.pwr_on[i] = s_r.pwr_req[0] & ~|s_r.ovc_latch;
			end else begin
				s_nxt.pwr_on[i] = s_r.pwr_req[i] & ~s_r.ovc_latch[i];
			end
		end
		if (access_wr) begin
			case (PADDR)
				ADDR_PORT_CTRL: begin
					s_nxt.pwr_req = PWDATA[3:0];
					s_nxt.gang_sw = PWDATA[CTRL_GANG_SW_BIT];
				end
				ADDR_EE_CTRL: begin
					s_nxt.ee_clk = PWDATA[EE_CLK_BIT];
					s_nxt.ee_dout = PWDATA[EE_DOUT_BIT];
					s_nxt.ee_doe = PWDATA[EE_DOE_BIT];
				end
				default: begin
				end
			endcase
		end
		// Read data and error settle in the setup cycle
		if (setup) begin
			s_nxt.prdata = PRDATA_RST;
			s_nxt.pslverr = 1'b0;
			case (PADDR)
				ADDR_STRAP_STATUS: begin
					s_nxt.prdata[STRAP_CLK_SRC_BIT] = s_r.clk_src;
					s_nxt.prdata[STRAP_PWR_SRC_BIT] = s_r.pwr_src;
					s_nxt.prdata[STRAP_EE_DIS_BIT] = s_r.ee_dis;
					s_nxt.prdata[STRAP_GANG_BIT] = gang;
					s_nxt.prdata[STRAP_CAPTURED_BIT] = s_r.captured;
				end
				ADDR_PORT_CTRL: begin
					s_nxt.prdata[3:0] = s_r.pwr_req;
					s_nxt.prdata[CTRL_GANG_SW_BIT] = s_r.gang_sw;
				end
				ADDR_PORT_STATUS: begin
					s_nxt.prdata[3:0] = ovc_f;
					s_nxt.prdata[STAT_LATCH_LSB +: 4] = s_r.ovc_latch;
					s_nxt.prdata[STAT_PWR_LSB +: 4] = s_r.pwr_on;
				end
				ADDR_EE_CTRL: begin
					s_nxt.prdata[EE_CLK_BIT] = s_r.ee_clk;
					s_nxt.prdata[EE_DOUT_BIT] = s_r.ee_dout;
					s_nxt.prdata[EE_DOE_BIT] = s_r.ee_doe;
					s_nxt.prdata[EE_DIN_BIT] = EEPROM_DATA_OR_GANG_STRAP_I;
				end
				default: begin
					s_nxt.pslverr = 1'b1;
				end
			endcase
		end
	end

	always_ff @(posedge CLOCK or posedge SYS_RST) begin
		if (SYS_RST) begin
			s_r <= '0;
			s_r.pwr_req <= PWR_REQ_RST;
			s_r.div <= DIV_RST;
			s_r.prdata <= PRDATA_RST;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign PRDATA = s_r.prdata;
	assign PREADY = 1'b1;
	assign PSLVERR = s_r.pslverr & PSEL & PENABLE;
	// PLL and oscillator run until the strap is known
	assign CORE_CLK_SEL_EXT = s_r.captured & s_r.clk_src;
	assign ANALOG_PLL_PWRDN = s_r.captured & s_r.clk_src;
	assign CRYSTAL_OSC_PWRDN = s_r.captured & s_r.clk_src;
	assign BUS_CLK_SYNC = s_r.bus_stb;
	assign BUS_POWERED = s_r.captured & s_r.pwr_src;
	assign PORT_POWER_ENABLE_N = ~s_r.pwr_on;
	// EEPROM pins are released until the strap is known
	assign EEPROM_SERIAL_CLOCK_O = s_r.ee_clk & ~s_r.ee_dis;
	assign EEPROM_SERIAL_CLOCK_OE = s_r.captured & ~s_r.ee_dis;
	assign EEPROM_SERIAL_CLOCK_PD_EN = s_r.captured & ~s_r.ee_dis;
	assign EEPROM_DATA_OR_GANG_STRAP_O = s_r.ee_dout & ~s_r.ee_dis;
	assign EEPROM_DATA_OR_GANG_STRAP_OE =
		s_r.captured & ~s_r.ee_dis & s_r.ee_doe;
	assign EEPROM_DATA_PD_EN = s_r.captured & ~s_r.ee_dis;

	default clocking cb @(posedge CLOCK); endclocking
	default disable iff (SYS_RST);

	sequence bus_gap_s;
		!BUS_CLK_SYNC [*3];
	endsequence
	sequence bus_tick_s;
		bus_gap_s ##1 BUS_CLK_SYNC;
	endsequence

	a_pll_select_strap: assert property ($rose(s_r.captured) |->
		CORE_CLK_SEL_EXT == $past(CLOCK_SOURCE_STRAP))
		else $error("Core clock select does not follow strap");
	a_pll_power_down: assert property ($rose(s_r.captured) |->
		ANALOG_PLL_PWRDN == $past(CLOCK_SOURCE_STRAP))
		else $error("PLL running while external clock selected");
	a_osc_power_down: assert property ($rose(s_r.captured) &&
		$past(CLOCK_SOURCE_STRAP) |-> CRYSTAL_OSC_PWRDN [*3])
		else $error("Oscillator not held powered down");
	a_bus_clk_tick: assert property (BUS_CLK_SYNC |=> bus_tick_s)
		else $error("Bus clock strobe not one in four");
	a_power_src_strap: assert property ($rose(s_r.captured) |->
		BUS_POWERED == $past(POWER_SOURCE_STRAP))
		else $error("Power source does not follow strap");
	a_ee_off_idle: assert property (s_r.ee_dis |->
		!EEPROM_SERIAL_CLOCK_OE && !EEPROM_DATA_OR_GANG_STRAP_OE)
		else $error("EEPROM pins driven while disabled");
	a_ee_pulldowns: assert property ($rose(s_r.captured) &&
		!$past(EEPROM_DISABLE_STRAP) |->
		EEPROM_SERIAL_CLOCK_PD_EN && EEPROM_DATA_PD_EN)
		else $error("EEPROM pulldowns off while enabled");
	a_ee_data_drive: assert property (EEPROM_DATA_OR_GANG_STRAP_OE |->
		!s_r.ee_dis && s_r.ee_doe)
		else $error("Data pin driven without enable");
	a_gang_select: assert property ($rose(s_r.captured) &&
		$past(EEPROM_DISABLE_STRAP) |->
		gang == $past(EEPROM_DATA_OR_GANG_STRAP_I))
		else $error("Gang mode not taken from shared pin");
	a_gang_all_off: assert property (gang && (|s_r.ovc_latch) |=>
		&PORT_POWER_ENABLE_N)
		else $error("Ganged overcurrent left a port powered");
	a_strap_hold: assert property (s_r.captured |=>
		$stable({s_r.clk_src, s_r.pwr_src, s_r.ee_dis, s_r.gang_pin}))
		else $error("Captured straps changed");
endmodule : hcs_clock_strap
`default_nettype wire

//--- sim/hcs_board.sv
// Board model: strap pins, fast clock source and the serial EEPROM pin
`timescale 1ns/100ps
`default_nettype none
module hcs_board (
	input wire logic [3:0] cfg,
	input wire logic dat_o,
	input wire logic dat_oe,
	input wire logic dat_pd,
	output logic clk_src,
	output logic pwr_src,
	output logic ee_dis,
	output logic dat_i
);
	// Fast clock comes from an oscillator, never a crystal overtone
	assign clk_src = cfg[0];
	// Levels are held unless a scenario moves them on purpose
	assign pwr_src = cfg[1];
	assign ee_dis = cfg[2];
	// Released pin falls to the pulldown; unpulled it shows a changed level, or the gang strap level cfg[3] when EEPROM is disabled
	always_comb begin
		if (dat_oe)
			dat_i = dat_o;
		else if (!cfg[2])
			dat_i = dat_pd ? 1'b0 : ~dat_o;
		else
			dat_i = cfg[3];
	end
endmodule : hcs_board
`default_nettype wire

//--- sim/hub_clock_and_strap_config_bench.sv
// Self-checking bench for the clock and strap block
`timescale 1ns/100ps
`default_nettype none
module hub_clock_and_strap_config_bench;
	logic CLOCK, SYS_RST, PSEL, PENABLE, PWRITE, PREADY, PSLVERR;
	logic [11:0] PADDR;
	logic [31:0] PWDATA, PRDATA;
	logic CLOCK_SOURCE_STRAP, POWER_SOURCE_STRAP, EEPROM_DISABLE_STRAP;
	logic EEPROM_DATA_OR_GANG_STRAP_I, EEPROM_DATA_OR_GANG_STRAP_O;
	logic EEPROM_DATA_OR_GANG_STRAP_OE, EEPROM_DATA_PD_EN;
	logic EEPROM_SERIAL_CLOCK_O, EEPROM_SERIAL_CLOCK_OE;
	logic EEPROM_SERIAL_CLOCK_PD_EN, CORE_CLK_SEL_EXT, ANALOG_PLL_PWRDN;
	logic CRYSTAL_OSC_PWRDN, BUS_CLK_SYNC, BUS_POWERED;
	logic [3:0] PORT_OVERCURRENT_N, PORT_POWER_ENABLE_N, cfg;
	logic [31:0] rd;
	logic er;
	int n_fail = 0;
	int checks_done = 0;
	hcs_clock_strap dut (.CLOCK(CLOCK), .SYS_RST(SYS_RST), .PSEL(PSEL),
		.PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR),
		.PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY),
		.PSLVERR(PSLVERR), .CLOCK_SOURCE_STRAP(CLOCK_SOURCE_STRAP),
		.POWER_SOURCE_STRAP(POWER_SOURCE_STRAP),
		.EEPROM_DISABLE_STRAP(EEPROM_DISABLE_STRAP),
		.EEPROM_DATA_OR_GANG_STRAP_I(EEPROM_DATA_OR_GANG_STRAP_I),
		.EEPROM_DATA_OR_GANG_STRAP_O(EEPROM_DATA_OR_GANG_STRAP_O),
		.EEPROM_DATA_OR_GANG_STRAP_OE(EEPROM_DATA_OR_GANG_STRAP_OE),
		.EEPROM_DATA_PD_EN(EEPROM_DATA_PD_EN),
		.EEPROM_SERIAL_CLOCK_O(EEPROM_SERIAL_CLOCK_O),
		.EEPROM_SERIAL_CLOCK_OE(EEPROM_SERIAL_CLOCK_OE),
		.EEPROM_SERIAL_CLOCK_PD_EN(EEPROM_SERIAL_CLOCK_PD_EN),
		.CORE_CLK_SEL_EXT(CORE_CLK_SEL_EXT),
		.ANALOG_PLL_PWRDN(ANALOG_PLL_PWRDN),
		.CRYSTAL_OSC_PWRDN(CRYSTAL_OSC_PWRDN),
		.BUS_CLK_SYNC(BUS_CLK_SYNC), .BUS_POWERED(BUS_POWERED),
		.PORT_OVERCURRENT_N(PORT_OVERCURRENT_N),
		.PORT_POWER_ENABLE_N(PORT_POWER_ENABLE_N));
	hcs_board brd (.cfg(cfg), .dat_o(EEPROM_DATA_OR_GANG_STRAP_O),
		.dat_oe(EEPROM_DATA_OR_GANG_STRAP_OE), .dat_pd(EEPROM_DATA_PD_EN),
		.clk_src(CLOCK_SOURCE_STRAP), .pwr_src(POWER_SOURCE_STRAP),
		.ee_dis(EEPROM_DISABLE_STRAP), .dat_i(EEPROM_DATA_OR_GANG_STRAP_I));
	initial begin
		CLOCK = 0;
		forever #12.5 CLOCK = ~CLOCK;
	end
	task automatic chk(string what, logic [31:0] seen, logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			n_fail++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
		end
	endtask : chk
	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", checks_done, n_fail);
		if (n_fail == 0 && checks_done > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : tally_and_finish
	// Entered just after a rising edge; leaves one idle edge behind it
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int n;
		PSEL <= 1;
		PWRITE <= w;
		PADDR <= a;
		PWDATA <= d;
		@(posedge CLOCK);
		PENABLE <= 1;
		// Answer is taken at the very edge that sees ready high
		for (n = 0; n < 16; n++) begin
			@(posedge CLOCK);
			if (PREADY === 1'b1) begin
				rd = PRDATA;
				er = PSLVERR;
				break;
			end
		end
		if (n == 16) begin
			chk("pready", 0, 1);
			tally_and_finish();
		end
		PSEL <= 0;
		PENABLE <= 0;
		@(posedge CLOCK);
	endtask : apb
	task automatic restart(input logic [3:0] c);
		SYS_RST <= 1;
		cfg <= c;
		PORT_OVERCURRENT_N <= 4'hf;
		repeat (12) @(posedge CLOCK);
		SYS_RST <= 0;
		repeat (3) @(posedge CLOCK);
	endtask : restart
	task automatic trip(input int k, input logic [3:0] exp);
		PORT_OVERCURRENT_N[k] <= 1'b0;
		repeat (9) @(posedge CLOCK);
		chk("power after fault", PORT_POWER_ENABLE_N, exp);
	endtask : trip
	task automatic test_pll_ganged;
		int pulses = 0;
		restart(4'b1110);
		chk("ext clk sel", CORE_CLK_SEL_EXT, 0);
		chk("pll pwrdn", ANALOG_PLL_PWRDN, 0);
		chk("osc pwrdn", CRYSTAL_OSC_PWRDN, 0);
		chk("bus powered", BUS_POWERED, 1);
		chk("ee clk oe", EEPROM_SERIAL_CLOCK_OE, 0);
		chk("ee data oe", EEPROM_DATA_OR_GANG_STRAP_OE, 0);
		chk("ee clk pulldown", EEPROM_SERIAL_CLOCK_PD_EN, 0);
		chk("ee data pulldown", EEPROM_DATA_PD_EN, 0);
		repeat (16) begin
			@(negedge CLOCK);
			pulses += BUS_CLK_SYNC;
		end
		chk("sync pulses", pulses, 4);
		@(posedge CLOCK);
		// Straps move after capture; captured view must not follow
		cfg <= 4'h0;
		apb(0, 12'h000, 0);
		chk("strap reg", rd, 32'h1e);
		chk("ext clk held", CORE_CLK_SEL_EXT, 0);
		chk("bus pwr held", BUS_POWERED, 1);
		apb(1, 12'h004, 32'h1);
		repeat (2) @(posedge CLOCK);
		chk("ganged on", PORT_POWER_ENABLE_N, 4'h0);
		trip(2, 4'hf);
		$display("test pll ganged done");
	endtask : test_pll_ganged
	task automatic test_ext_eeprom;
		restart(4'b0001);
		chk("ext clk sel", CORE_CLK_SEL_EXT, 1);
		chk("pll pwrdn", ANALOG_PLL_PWRDN, 1);
		chk("osc pwrdn", CRYSTAL_OSC_PWRDN, 1);
		chk("bus powered", BUS_POWERED, 0);
		chk("clk pulldown", EEPROM_SERIAL_CLOCK_PD_EN, 1);
		chk("data pulldown", EEPROM_DATA_PD_EN, 1);
		apb(1, 12'h00c, 32'h7);
		chk("ee clk out", EEPROM_SERIAL_CLOCK_O, 1);
		chk("ee clk driven", EEPROM_SERIAL_CLOCK_OE, 1);
		chk("ee data oe", EEPROM_DATA_OR_GANG_STRAP_OE, 1);
		chk("ee data out", EEPROM_DATA_OR_GANG_STRAP_O, 1);
		apb(0, 12'h00c, 0);
		chk("ee data in hi", rd, 32'hf);
		apb(1, 12'h00c, 0);
		apb(0, 12'h00c, 0);
		chk("ee data in lo", rd, 32'h0);
		apb(0, 12'h010, 0);
		chk("unmapped err", er, 1);
		chk("unmapped data", rd, 0);
		apb(1, 12'h004, 32'h5);
		repeat (2) @(posedge CLOCK);
		chk("per port on", PORT_POWER_ENABLE_N, 4'ha);
		trip(0, 4'hb);
		apb(0, 12'h008, 0);
		chk("port status", rd, 32'h411);
		// Sticky bit outlives the fault until software clears it
		PORT_OVERCURRENT_N[0] <= 1'b1;
		repeat (6) @(posedge CLOCK);
		apb(1, 12'h008, 32'h10);
		apb(0, 12'h008, 0);
		chk("status cleared", rd, 32'h500);
		apb(1, 12'h004, 32'h11);
		apb(0, 12'h000, 0);
		chk("strap gang sel", rd, 32'h19);
		chk("gang sw on", PORT_POWER_ENABLE_N, 4'h0);
		trip(3, 4'hf);
		$display("test ext eeprom done");
	endtask : test_ext_eeprom
	initial begin
		SYS_RST = 1;
		PSEL = 0;
		PENABLE = 0;
		PWRITE = 0;
		PADDR = 12'h000;
		PWDATA = 32'h0;
		cfg = 4'h0;
		PORT_OVERCURRENT_N = 4'hf;
		@(posedge CLOCK);
		test_pll_ganged();
		test_ext_eeprom();
		tally_and_finish();
	end
endmodule : hub_clock_and_strap_config_bench
`default_nettype wire
